// *** rtl/remote_command_receiver.v ***
// remote command receiver: frame decoder, command outputs, apb status
//
// What this block does
// - two local keys pressed together yield one of ten codes, overriding link.
// - signal counter counts carrier ticks, local counter counts 40 kHz ticks.
// - 3.2 ms of steady carrier overflows signal counter, clearing both counters.
// - local counter samples signal counter; both resync each frame, tolerating 24 percent.
// - five bits after sync compare against fixed preamble; mismatch marks invalid.
// - next five bits form command; output only if equal to previous and preamble good.
// - differing command disables outputs at once and is stored for next frame.
// - outputs enable in end frame of second match; disable 45 ms later.
// - rest state drives all binary outputs high; command bits otherwise shown.
// - data-valid low at rest, high while a command is presented.
// - code 11011 gives 2.44 Hz square wave on pulse output, else zero.
// - on/off output toggles on each new appearance of code 01111.
// - three analog outputs are 10 kHz pulse trains, 64 duty steps each.
// - six codes raise or lower duties; full sweep paced to 6.6 s.
// - code 01011 sets all three analog duties to fifty percent.
// - code 01100 mutes analog A, next appearance restores remembered duty.
// - reset clears pulse and on/off, sets duties fifty percent, mutes A.
// - message holds sync, five preamble, five command, end bit.
//
// Our own choices: the address map and register access over APB.
`default_nettype none
`include "remote_rx_defs.vh"
module remote_command_receiver #(
  parameter TICK_DIV   = `TICK_DIV,
  parameter HOLD_TICKS = `HOLD_TICKS,
  parameter STEP_TICKS = `STEP_TICKS
) (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        carrier_in,
  input  wire [4:0]  key_n,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  output reg  [4:0]  code_out_r,
  output reg         data_valid_r,
  output reg         pulse_train_r,
  output reg         on_off_r,
  output wire        analog_a,
  output wire        analog_b,
  output wire        analog_c
);
  // ------------------------------------------------------------
  // 40 kHz tick and counters
  // ------------------------------------------------------------
  reg [9:0]  div_r;
  reg        tick_r;
  reg [7:0]  sig_cnt_r;
  reg [7:0]  loc_cnt_r;
  reg        in_frame_r;
  reg        carrier_d_r;
  reg        slot_seen_r;
  reg [3:0]  bit_idx_r;
  reg [4:0]  pre_r;
  reg [4:0]  cmd_r;
  reg [4:0]  stored_r;
  reg        stored_ok_r;
  reg        present_r;
  reg [20:0] hold_r;
  reg [4:0]  shown_r;
  reg        sw_disable_r;
  wire       overflow = (sig_cnt_r == `FRAME_TICKS - 1) & tick_r & carrier_in;

  // divider for the 40 kHz local tick
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_r  <= 10'h000;
      tick_r <= 1'b0;
    end else begin
      tick_r <= (div_r == TICK_DIV - 1);
      div_r  <= (div_r == TICK_DIV - 1) ? 10'h000 : div_r + 10'h001;
    end
  end

  // signal counter counts ticks with carrier; local counter all ticks
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sig_cnt_r   <= 8'h00;
      loc_cnt_r   <= 8'h00;
      carrier_d_r <= 1'b0;
      slot_seen_r <= 1'b0;
    end else if (tick_r) begin
      carrier_d_r <= carrier_in;
      if (overflow) begin
        sig_cnt_r   <= 8'h00;
        loc_cnt_r   <= 8'h00;
        slot_seen_r <= 1'b0; // sync carrier must not read as a data one
      end else if (carrier_in & ~carrier_d_r) begin
        sig_cnt_r   <= 8'h01;
        loc_cnt_r   <= 8'h00;
        slot_seen_r <= 1'b0;
      end else begin
        sig_cnt_r <= carrier_in ? sig_cnt_r + 8'h01 : sig_cnt_r;
        loc_cnt_r <= (loc_cnt_r == 8'hff) ? loc_cnt_r : loc_cnt_r + 8'h01;
        if (loc_cnt_r > `SAMPLE_TICKS / 2 && carrier_in)
          slot_seen_r <= 1'b1;
      end
    end
  end

  // ------------------------------------------------------------
  // frame decode and two-transmission check
  // ------------------------------------------------------------
  wire sample = tick_r & in_frame_r & (loc_cnt_r == `SAMPLE_TICKS);
  wire bit_val = slot_seen_r | carrier_in;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      in_frame_r  <= 1'b0;
      bit_idx_r   <= 4'h0;
      pre_r       <= 5'h00;
      cmd_r       <= 5'h00;
      stored_r    <= `CODE_REST;
      stored_ok_r <= 1'b0;
      present_r   <= 1'b0;
      hold_r      <= 21'h000000;
    end else begin
      if (overflow) begin
        in_frame_r <= 1'b1;
        bit_idx_r  <= 4'h0;
      end else if (sample) begin
        bit_idx_r <= bit_idx_r + 4'h1;
        if (bit_idx_r < 4'h5)
          pre_r <= {pre_r[3:0], bit_val};
        else if (bit_idx_r < 4'ha)
          cmd_r <= {cmd_r[3:0], bit_val};
        else begin
          in_frame_r <= 1'b0;
          if (pre_r != `PREAMBLE) begin
            stored_ok_r <= 1'b0;
          end else if (stored_ok_r && cmd_r == stored_r) begin
            present_r <= 1'b1;
            hold_r    <= HOLD_TICKS[20:0];
          end else begin
            present_r   <= 1'b0;
            stored_r    <= cmd_r;
            stored_ok_r <= 1'b1;
          end
        end
      end
      // idle countdown disables presentation after silence
      if (tick_r && present_r && !(sample && bit_idx_r == 4'ha)) begin
        if (hold_r == 21'h000001)
          present_r <= 1'b0;
        hold_r <= hold_r - 21'h000001;
      end
    end
  end

  // ------------------------------------------------------------
  // local keys and binary outputs
  // ------------------------------------------------------------
  reg [4:0] key_code;
  reg       key_hit;
  // pairs of keys give one of ten codes
  always @* begin
    key_hit  = 1'b1;
    case (~key_n)
      5'h03:   key_code = `CODE_INC_A;
      5'h05:   key_code = `CODE_DEC_A;
      5'h09:   key_code = `CODE_INC_B;
      5'h11:   key_code = `CODE_DEC_B;
      5'h06:   key_code = `CODE_INC_C;
      5'h0a:   key_code = `CODE_DEC_C;
      5'h12:   key_code = `CODE_HALF;
      5'h0c:   key_code = `CODE_ONOFF;
      5'h14:   key_code = `CODE_MUTE;
      5'h18:   key_code = `CODE_PULSE;
      default: begin
        key_code = `CODE_REST;
        key_hit  = 1'b0;
      end
    endcase
  end

  wire [4:0] next_code = sw_disable_r ? `CODE_REST :
                         key_hit ? key_code :
                         present_r ? stored_r : `CODE_REST;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      code_out_r   <= `CODE_REST;
      data_valid_r <= 1'b0;
      shown_r      <= `CODE_REST;
    end else begin
      code_out_r   <= next_code;
      data_valid_r <= (next_code != `CODE_REST);
      shown_r      <= code_out_r;
    end
  end

  wire appear = (code_out_r != shown_r);

  // ------------------------------------------------------------
  // pulse train, on/off, analog duties
  // ------------------------------------------------------------
  reg [13:0] pt_cnt_r;
  reg [17:0] step_cnt_r;
  reg [5:0]  duty_r [0:2];
  reg        muted_r;

  // pulse train and toggle output
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pt_cnt_r      <= 14'h0000;
      pulse_train_r <= 1'b0;
      on_off_r      <= 1'b0;
    end else begin
      if (code_out_r != `CODE_PULSE) begin
        pt_cnt_r      <= 14'h0000;
        pulse_train_r <= 1'b0;
      end else if (tick_r) begin
        if (pt_cnt_r == `PULSE_HALF_TICKS - 1) begin
          pt_cnt_r      <= 14'h0000;
          pulse_train_r <= ~pulse_train_r;
        end else
          pt_cnt_r <= pt_cnt_r + 14'h0001;
      end
      if (appear && code_out_r == `CODE_ONOFF)
        on_off_r <= ~on_off_r;
    end
  end

  // constant table: which output, which direction
  reg [1:0] step_ch;
  reg       step_up;
  reg       step_any;
  always @* begin
    step_any = 1'b1;
    step_up  = 1'b1;
    step_ch  = 2'd0;
    case (code_out_r)
      `CODE_INC_A: step_ch = 2'd0;
      `CODE_DEC_A: step_up = 1'b0;
      `CODE_INC_B: step_ch = 2'd1;
      `CODE_DEC_B: begin
        step_ch = 2'd1;
        step_up = 1'b0;
      end
      `CODE_INC_C: step_ch = 2'd2;
      `CODE_DEC_C: begin
        step_ch = 2'd2;
        step_up = 1'b0;
      end
      default: step_any = 1'b0;
    endcase
  end

  wire step_now = tick_r & step_any & (step_cnt_r == STEP_TICKS - 1);

  // duty stepping, half reset and mute
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      step_cnt_r <= 18'h00000;
      duty_r[0]  <= `DUTY_HALF;
      duty_r[1]  <= `DUTY_HALF;
      duty_r[2]  <= `DUTY_HALF;
      muted_r    <= 1'b1;
    end else begin
      if (!step_any)
        step_cnt_r <= 18'h00000;
      else if (tick_r)
        step_cnt_r <= step_now ? 18'h00000 : step_cnt_r + 18'h00001;
      if (appear && code_out_r == `CODE_HALF) begin
        duty_r[0] <= `DUTY_HALF;
        duty_r[1] <= `DUTY_HALF;
        duty_r[2] <= `DUTY_HALF;
      end else if (step_now) begin
        if (step_up && duty_r[step_ch] != 6'h3f)
          duty_r[step_ch] <= duty_r[step_ch] + 6'h01;
        else if (!step_up && duty_r[step_ch] != 6'h00)
          duty_r[step_ch] <= duty_r[step_ch] - 6'h01;
      end
      if (appear && code_out_r == `CODE_MUTE)
        muted_r <= ~muted_r;
    end
  end

  wire [5:0] duty_a = muted_r ? 6'h00 : duty_r[0];

  wire [2:0] pwm_out;

  // three pwm outputs, one per analog channel
  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : g_pwm
      duty_pwm #(
        .PERIOD(`PWM_CLKS)
      ) u_pwm (
        .pclk    (pclk),
        .presetn (presetn),
        .duty    ((g == 0) ? duty_a : duty_r[g]),
        .pwm_r   (pwm_out[g])
      );
    end
  endgenerate

  // analog pins straight from the pwm flops
  assign analog_a = pwm_out[0];
  assign analog_b = pwm_out[1];
  assign analog_c = pwm_out[2];

  // ------------------------------------------------------------
  // apb slave, zero wait
  // ------------------------------------------------------------
  assign pready  = 1'b1;
  assign pslverr = 1'b0;
  wire   wr      = psel & penable & pwrite;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sw_disable_r <= 1'b0;
      prdata       <= 32'h00000000;
    end else begin
      if (wr && paddr == `REG_CTRL)
        sw_disable_r <= pwdata[0];
      if (psel && !penable && !pwrite) begin
        case (paddr)
          `REG_CTRL:   prdata <= {31'h0, sw_disable_r};
          `REG_STATUS: prdata <= {22'h0, muted_r, on_off_r, pulse_train_r,
                                  data_valid_r, present_r, code_out_r};
          `REG_DUTY:   prdata <= {14'h0, duty_r[2], duty_r[1], duty_r[0]};
          default:     prdata <= 32'h00000000;
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// *** rtl/remote_rx_defs.vh ***
// constants for the remote command receiver
`ifndef REMOTE_RX_DEFS_VH
`define REMOTE_RX_DEFS_VH
`define CLK_HZ          25000000
`define TICK_HZ         40000
`define TICK_DIV        (`CLK_HZ / `TICK_HZ)
`define FRAME_US        3200
`define FRAME_TICKS     ((`FRAME_US * `TICK_HZ) / 1000000)
`define SAMPLE_US       1000
`define SAMPLE_TICKS    ((`SAMPLE_US * `TICK_HZ) / 1000000)
`define HOLD_MS         45
`define HOLD_TICKS      ((`HOLD_MS * `TICK_HZ) / 1000)
`define PULSE_HZ_X100   244
`define PULSE_HALF_TICKS ((`TICK_HZ * 100) / (`PULSE_HZ_X100 * 2))
`define PWM_HZ          10000
`define PWM_CLKS        (`CLK_HZ / `PWM_HZ)
`define SWEEP_MS        6600
`define STEP_TICKS      ((`SWEEP_MS * `TICK_HZ) / (1000 * 63))
`define PREAMBLE        5'h0a
`define CODE_REST       5'h1f
`define CODE_PULSE      5'h1b
`define CODE_ONOFF      5'h0f
`define CODE_HALF       5'h0b
`define CODE_MUTE       5'h0c
`define CODE_INC_A      5'h1a
`define CODE_DEC_A      5'h1e
`define CODE_INC_B      5'h13
`define CODE_DEC_B      5'h06
`define CODE_INC_C      5'h01
`define CODE_DEC_C      5'h15
`define DUTY_HALF       6'h20
`define REG_CTRL        12'h000
`define REG_STATUS      12'h004
`define REG_DUTY        12'h008
`endif

// *** rtl/duty_pwm.v ***
// one 10 kHz duty-factor output with 64 steps
`default_nettype none
module duty_pwm #(
  parameter PERIOD = 2500
) (
  input  wire       pclk,
  input  wire       presetn,
  input  wire [5:0] duty,
  output reg        pwm_r
);
  reg [11:0] cnt_r;
  wire [17:0] thr = duty * PERIOD[11:0];
  // period counter and compare; full step 63 means 100 percent
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= 12'h000;
      pwm_r <= 1'b0;
    end else begin
      cnt_r <= (cnt_r == PERIOD - 1) ? 12'h000 : cnt_r + 12'h001;
      pwm_r <= ({6'h00, cnt_r} * 18'd63) < thr;
    end
  end
endmodule
`default_nettype wire

// *** test/rcr_assertions.sv ***
// port checker for the remote command receiver
`default_nettype none
module rcr_checker #(
  parameter HOLD_TICKS = 20,
  parameter STEP_TICKS = 2
) (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        carrier_in,
  input wire logic [4:0]  key_n,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [4:0]  code_out_r,
  input wire logic        data_valid_r,
  input wire logic        pulse_train_r,
  input wire logic        on_off_r,
  input wire logic        analog_a,
  input wire logic        analog_b,
  input wire logic        analog_c
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ----------------
  // output relations
  // ----------------
  valid_tracks_code_a: assert property (
    data_valid_r == (code_out_r != 5'h1f)) else $error("valid flag disagrees with code");
  pulse_idle_low_a: assert property (
    (code_out_r != 5'h1b && $past(code_out_r) != 5'h1b) |-> !pulse_train_r)
    else $error("pulse train active without its code");
  onoff_cause_a: assert property (
    $changed(on_off_r) |-> code_out_r == 5'h0f || $past(code_out_r) == 5'h0f)
    else $error("on_off changed without its code");
  onoff_once_a: assert property (
    (code_out_r == 5'h0f)[*4] |-> $stable(on_off_r)) else $error("on_off toggled twice");
  key_command_a: assert property (
    ($countones(~key_n) == 2)[*4] |-> code_out_r != 5'h1f) else $error("key pair gave no code");
  reset_state_a: assert property (
    $rose(presetn) |-> code_out_r == 5'h1f && !on_off_r && !pulse_train_r)
    else $error("outputs not cleared by reset");
  apb_no_wait_a: assert property (psel |-> pready && !pslverr) else $error("apb wait or error");
  unmapped_zero_a: assert property (
    psel && penable && !pwrite && paddr > 12'h008 |-> prdata == 32'h0)
    else $error("unmapped read not zero");
  status_code_a: assert property (
    psel && penable && !pwrite && paddr == 12'h004 && $stable(code_out_r)
    |-> prdata[4:0] == code_out_r) else $error("status code mismatch");
  cover property (code_out_r == 5'h0f);
  cover property ($changed(on_off_r));
  cover property (psel && penable && !pwrite);
endmodule
bind remote_command_receiver rcr_checker #(.HOLD_TICKS(HOLD_TICKS), .STEP_TICKS(STEP_TICKS))
  u_chk (.pclk, .presetn, .carrier_in, .key_n, .psel, .penable, .pwrite, .paddr, .pwdata,
  .prdata, .pready, .pslverr, .code_out_r, .data_valid_r, .pulse_train_r, .on_off_r,
  .analog_a, .analog_b, .analog_c);
`default_nettype wire

// *** test/remote_tx_model.sv ***
// behavioural remote transmitter driving the carrier envelope
`default_nettype none
module remote_tx_model #(
  parameter TICK = 625
) (
  input  wire logic       pclk,
  input  wire logic       go,
  input  wire logic [4:0] cmd,
  output var  logic       carrier
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [11:0] msg;
  // messages repeat while go stays high, sync frame first
  initial begin
    carrier = 1'b0;
    forever begin
      @(posedge pclk iff go);
      // command goes out msb first
      msg = {1'b1, cmd[0], cmd[1], cmd[2], cmd[3], cmd[4], 5'b01010, 1'b1};
      for (int b = 0; b < 12; b++) begin
        carrier <= 1'b1;
        repeat (16 * TICK) @(posedge pclk);
        carrier <= msg[b];
        repeat (48 * TICK) @(posedge pclk);
        carrier <= (b == 0);
        repeat (64 * TICK) @(posedge pclk);
      end
      carrier <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// *** test/remote_command_receiver_test.sv ***
// self-checking bench for the remote command receiver
`default_nettype none
module remote_command_receiver_test;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------
  // signals and model state
  // ----------------
  logic        pclk, presetn, psel, penable, pwrite, go, vld, pready, pslverr;
  logic        data_valid_r, pulse_train_r, on_off_r, carrier_in;
  logic        analog_a, analog_b, analog_c;
  logic [4:0]  key_n, code_out_r, got, pair_of [32];
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  wire  [2:0]  an;
  integer      seed;
  int          n_fail, n_compared, hi, onoff_m, mute_m, n, idx [$];
  localparam int TK = 8; // pclk cycles per link tick, shortened for the bench
  logic [4:0]  want [$] = '{5'h1b, 5'h0f, 5'h0b, 5'h0c, 5'h1a, 5'h1e, 5'h13, 5'h06, 5'h01, 5'h15};
  assign an = {analog_c, analog_b, analog_a};
  // clock
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  remote_command_receiver #(.HOLD_TICKS(20), .STEP_TICKS(2), .TICK_DIV(TK)) DUT (.pclk,
    .presetn, .carrier_in, .key_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .code_out_r, .data_valid_r, .pulse_train_r, .on_off_r, .analog_a,
    .analog_b, .analog_c);
  remote_tx_model #(.TICK(TK)) TX (.pclk, .go, .cmd(5'h05), .carrier(carrier_in));
  // ----------------
  // tasks
  // ----------------
  task automatic check(input string what, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic press(input logic [4:0] k, input int hold);
    key_n <= ~k;
    repeat (hold) @(posedge pclk);
    got = code_out_r;
    vld = data_valid_r;
    key_n <= 5'h1f;
    for (int t = 0; t < 30 && data_valid_r !== 1'b0; t++) @(posedge pclk);
    @(posedge pclk);
  endtask
  task automatic meas(input int s, input int e);
    hi = 0;
    repeat (2500) @(posedge pclk);
    repeat (2500) begin
      @(posedge pclk);
      hi += an[s];
    end
    check("analog high cycles", e, (hi - e <= 40 && e - hi <= 40) ? e : hi);
  endtask
  task automatic tally_and_finish;
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // watchdog
  initial begin
    #(95000 * 40);
    n_fail++;
    $display("CHECK FAILED watchdog expected done seen hang");
    tally_and_finish();
  end
  // ----------------
  // main sequence
  // ----------------
  initial begin
    seed = 32'hb0360bf5;
    {presetn, psel, penable, pwrite, go} = 5'h00;
    paddr = 12'h000;
    pwdata = 32'h0;
    key_n = 5'h1f;
    mute_m = 1;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    check("code at rest", 5'h1f, code_out_r);
    check("valid at rest", 1'b0, data_valid_r);
    check("pulse at rest", 1'b0, pulse_train_r);
    apb(1'b0, 12'h004, 32'h0);
    check("status", 32'h21f, rd & 32'h3df);
    apb(1'b0, 12'h008, 32'h0);
    check("duty b c", 12'h820, rd[17:6]);
    apb(1'b1, 12'h000, 32'h1);
    apb(1'b0, 12'h000, 32'h0);
    check("ctrl readback", 32'h1, rd);
    press(5'h03, 3);
    check("code while disabled", 5'h1f, got);
    apb(1'b1, 12'h000, 32'h0);
    apb(1'b0, 12'h100 | ($random(seed) & 12'h0fc), 32'h0);
    check("unmapped read", 32'h0, rd);
    meas(0, 0);
    for (int s = 1; s < 3; s++) meas(s, 1250);
    for (int i = 0; i < 5; i++) begin
      for (int j = i + 1; j < 5; j++) begin
        press((5'h01 << i) | (5'h01 << j), 4 + ($random(seed) & 3));
        check("valid with keys", 1'b1, vld);
        idx = want.find_first_index with (item == got);
        if (idx.size() != 0) want.delete(idx[0]);
        pair_of[got] = (5'h01 << i) | (5'h01 << j);
        onoff_m ^= (got == 5'h0f);
        mute_m ^= (got == 5'h0c);
      end
    end
    check("codes left unseen", 0, want.size());
    check("on_off after scan", onoff_m, on_off_r);
    press(pair_of[5'h0f], 12);
    check("on_off toggled once", onoff_m ^ 1, on_off_r);
    press(pair_of[5'h0b], 6);
    apb(1'b0, 12'h008, 32'h0);
    check("duty half", 12'h820, rd[17:6]);
    for (int m = 0; m < 2; m++) begin
      press(pair_of[5'h0c], 6);
      mute_m ^= 1;
      meas(0, mute_m ? 0 : 1250);
    end
    press(pair_of[5'h13], 60);
    press(pair_of[5'h15], 60);
    apb(1'b0, 12'h008, 32'h0);
    check("duty b raised", 1'b1, rd[11:6] inside {6'h23, 6'h24});
    check("duty c lowered", 1'b1, rd[17:12] inside {6'h1c, 6'h1d});
    // external reset in mid-run
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    check("on_off after reset", 1'b0, on_off_r);
    apb(1'b0, 12'h004, 32'h0);
    check("status after reset", 32'h21f, rd & 32'h3df);
    // two identical messages from the far side
    n = 0;
    go <= 1'b1;
    while (data_valid_r !== 1'b1 && n < 26 * 128 * TK) begin
      @(posedge pclk);
      n++;
    end
    go <= 1'b0;
    check("link valid time", 1'b1, n >= 23 * 128 * TK && n <= 24 * 128 * TK + 8);
    check("link code", 5'h05, code_out_r);
    repeat (150) @(posedge pclk);
    check("link held", 1'b1, data_valid_r);
    repeat (20) @(posedge pclk);
    check("link rest after hold", 5'h1f, code_out_r);
    tally_and_finish();
  end
endmodule
`default_nettype wire
